// ---- pkg/sic_pkg.sv ----
// Register map, field positions and reset values of the serial control/status block
package sic_pkg;
	localparam int SIC_AW = 6;
	// Register byte offsets
	localparam logic [5:0] SIC_OFF_CTRL1 = 6'h00;
	localparam logic [5:0] SIC_OFF_CTRL2 = 6'h04;
	localparam logic [5:0] SIC_OFF_STS = 6'h08;
	localparam logic [5:0] SIC_OFF_DATA = 6'h0C;
	localparam logic [5:0] SIC_OFF_POLY = 6'h10;
	localparam logic [5:0] SIC_OFF_RX_CHECKSUM = 6'h14;
	localparam logic [5:0] SIC_OFF_TX_CHECKSUM = 6'h18;
	localparam logic [5:0] SIC_OFF_I2S = 6'h1C;
	localparam logic [5:0] SIC_OFF_CLKP = 6'h20;
	// Reset values and writable masks
	localparam logic [15:0] SIC_RST_ZERO = 16'h0000;
	localparam logic [15:0] SIC_RST_POLY = 16'h0007;
	localparam logic [15:0] SIC_RST_CLKP = 16'h0002;
	localparam logic [15:0] SIC_MSK_CTRL2 = 16'h01E7;
	localparam logic [15:0] SIC_MSK_I2S = 16'h0FBF;
	localparam logic [15:0] SIC_MSK_CLKP = 16'h0FFF;
	// First control register fields
	localparam int SIC_C1_CRCEN = 13;
	localparam int SIC_C1_WIDE = 11;
	localparam int SIC_C1_DIVLO = 3;
	localparam int SIC_C1_MASTER = 2;
	// Second control register fields: divider top bit, interrupt enables, hardware select, DMA
	localparam int SIC_C2_DIVHI = 8;
	localparam int SIC_C2_TXEIE = 7;
	localparam int SIC_C2_RXFIE = 6;
	localparam int SIC_C2_ERROR_IRQ_ENABLE = 5;
	localparam int SIC_C2_HWSEL = 2;
	localparam int SIC_C2_TXDMA = 1;
	localparam int SIC_C2_RXDMA = 0;
	// Status fields
	localparam int SIC_ST_BUSY = 7;
	localparam int SIC_ST_OVR = 6;
	localparam int SIC_ST_MMF = 5;
	localparam int SIC_ST_CRC = 4;
	localparam int SIC_ST_UDR = 3;
	localparam int SIC_ST_SIDE = 2;
	localparam int SIC_ST_TXE = 1;
	localparam int SIC_ST_RXF = 0;
	// Audio configuration fields
	localparam int SIC_I2_MODE = 11;
	localparam int SIC_I2_EN = 10;
	localparam int SIC_I2_ROLE = 8;
	localparam int SIC_I2_PCMLONG = 7;
	localparam int SIC_I2_STD = 4;
	localparam int SIC_I2_CKPOL = 3;
	localparam int SIC_I2_LEN = 1;
	localparam int SIC_I2_CH32 = 0;
	localparam logic [1:0] SIC_LEN_16 = 2'h0;
	// Audio prescaler fields
	localparam int SIC_CP_MCLKOE = 9;
	localparam int SIC_CP_ODD = 8;
endpackage

// ---- rtl/sic_regs.sv ----
// Control, status, data, checksum and audio configuration registers of the serial controller
// Function
// - Divider select top bit in control2 bit8
// - Buffer empty/full interrupt enables bits 7,6
// - Error interrupt enable bit5 gates errors
// - Master hardware select drives select low
// - DMA transmit/receive requests gated by enables
// - Status bit7 reports busy
// - Receive overrun flag at status bit6
// - Fault cleared by status access then control1 write
// - Checksum mismatch cleared by writing zero
// - Underrun flag cleared by status read
// - Status bit2 shows current audio side in audio mode, zero otherwise
// - Tx empty resets one, rx full zero
// - Sixteen-bit data register, byte frames low
// - Writable polynomial, reset 0x0007
// - Checksums accumulate outside audio mode, zeroed when disabled
// - Eight or sixteen bit checksum per width
// - Audio mode, enable and role bits
// - Framing standard and pulse sync length
// - Audio clock idle level bit3
// - Sample length, channel width forced otherwise
// - Master clock output enable bit9
// - Audio divider twice value plus odd
// - Baud divide is two power select+1 up to select 9, zero above
`timescale 1ns/1ps
module sic_regs (
	input wire logic clk,
	input wire logic resetn,
	input wire logic [sic_pkg::SIC_AW-1:0] addr,
	input wire logic [15:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [15:0] rdata,
	input wire logic busy,
	input wire logic rx_valid,
	input wire logic [15:0] rx_word,
	input wire logic tx_take,
	output logic [15:0] tx_word,
	output logic tx_ready,
	input wire logic mode_fault_evt,
	input wire logic crc_err_evt,
	input wire logic underrun_evt,
	input wire logic audio_side,
	output logic irq,
	output logic tx_dma_req,
	output logic rx_dma_req,
	output logic sel_out,
	output logic sel_oe,
	output logic spi_master,
	output logic frame_wide,
	output logic [3:0] baud_divider_select,
	output logic [10:0] baud_ratio,
	output logic audio_mode_select,
	output logic audio_enable,
	output logic [1:0] audio_role_select,
	output logic [1:0] audio_framing_select,
	output logic pulse_code_sync_length,
	output logic audio_clock_idle_level,
	output logic [1:0] audio_sample_length,
	output logic audio_ch32,
	output logic [10:0] audio_divider,
	output logic audio_master_clock_out_enable
);
	import sic_pkg::*;

	typedef struct packed {
		logic [15:0] ctrl1;
		logic [15:0] ctrl2;
		logic ovr;
		logic mmf;
		logic crcerr;
		logic udr;
		logic txe;
		logic rxf;
		logic sts_seen;
		logic ovr_armed;
		logic [15:0] tx_buf;
		logic [15:0] rx_buf;
		logic [15:0] poly;
		logic [15:0] rx_checksum;
		logic [15:0] tx_checksum;
		logic [15:0] i2s;
		logic [15:0] clkp;
		logic [15:0] rdata;
		logic [15:0] tx_word;
	} sic_state_s;

	sic_state_s st_r;
	sic_state_s st_nxt;
	logic wide;
	logic spi_side;
	logic [15:0] sts_word;

	// Serial checksum step, MSB first, over a byte or a half-word
	function automatic logic [15:0] sic_crc_step(input logic [15:0] crc, input logic [15:0] d,
		input logic [15:0] poly, input logic w);
		logic [15:0] c;
		logic fb;
		c = crc;
		fb = 1'b0;
		for (int i = 15; i >= 0; i--) begin
			if (w || i < 8) begin
				fb = (w ? c[15] : c[7]) ^ d[i];
				c = {c[14:0], 1'b0};
				if (fb) begin
					c = c ^ poly;
				end
			end
		end
		if (!w) begin
			c[15:8] = 8'h00;
		end
		return c;
	endfunction

	// Byte frames keep only the low byte
	function automatic logic [15:0] sic_frame(input logic [15:0] d, input logic w);
		return w ? d : {8'h00, d[7:0]};
	endfunction

	assign wide = st_r.ctrl1[SIC_C1_WIDE];
	assign spi_side = !st_r.i2s[SIC_I2_MODE];

	// Status word as software sees it
	always_comb begin
		sts_word = SIC_RST_ZERO;
		sts_word[SIC_ST_BUSY] = busy;
		sts_word[SIC_ST_OVR] = st_r.ovr;
		sts_word[SIC_ST_MMF] = st_r.mmf;
		sts_word[SIC_ST_CRC] = st_r.crcerr;
		sts_word[SIC_ST_UDR] = st_r.udr;
		sts_word[SIC_ST_SIDE] = !spi_side & audio_side;
		sts_word[SIC_ST_TXE] = st_r.txe;
		sts_word[SIC_ST_RXF] = st_r.rxf;
	end

	// Next state: bus writes, reads with side effects, engine events
	always_comb begin
		st_nxt = st_r;
		st_nxt.rdata = SIC_RST_ZERO;
		if (wr) begin
			unique case (addr)
				SIC_OFF_CTRL1: begin
					st_nxt.ctrl1 = wdata;
					if (st_r.sts_seen) begin
						st_nxt.mmf = 1'b0;
					end
					st_nxt.sts_seen = 1'b0;
				end
				SIC_OFF_CTRL2: st_nxt.ctrl2 = wdata & SIC_MSK_CTRL2;
				SIC_OFF_STS: begin
					st_nxt.sts_seen = 1'b1;
					if (!wdata[SIC_ST_CRC]) begin
						st_nxt.crcerr = 1'b0;
					end
				end
				SIC_OFF_DATA: begin
					st_nxt.tx_buf = sic_frame(wdata, wide);
					st_nxt.txe = 1'b0;
				end
				SIC_OFF_POLY: st_nxt.poly = wdata;
				SIC_OFF_I2S: st_nxt.i2s = wdata & SIC_MSK_I2S;
				SIC_OFF_CLKP: st_nxt.clkp = wdata & SIC_MSK_CLKP;
				default: ;
			endcase
		end
		if (rd) begin
			unique case (addr)
				SIC_OFF_CTRL1: st_nxt.rdata = st_r.ctrl1;
				SIC_OFF_CTRL2: st_nxt.rdata = st_r.ctrl2;
				SIC_OFF_STS: begin
					st_nxt.rdata = sts_word;
					st_nxt.sts_seen = 1'b1;
					st_nxt.udr = 1'b0;
					st_nxt.ovr_armed = st_r.ovr;
				end
				SIC_OFF_DATA: begin
					st_nxt.rdata = st_r.rx_buf;
					st_nxt.rxf = 1'b0;
					if (st_r.ovr_armed) begin
						st_nxt.ovr = 1'b0;
					end
					st_nxt.ovr_armed = 1'b0;
				end
				SIC_OFF_POLY: st_nxt.rdata = st_r.poly;
				SIC_OFF_RX_CHECKSUM: st_nxt.rdata = st_r.rx_checksum;
				SIC_OFF_TX_CHECKSUM: st_nxt.rdata = st_r.tx_checksum;
				SIC_OFF_I2S: st_nxt.rdata = st_r.i2s;
				SIC_OFF_CLKP: st_nxt.rdata = st_r.clkp;
				default: st_nxt.rdata = SIC_RST_ZERO;
			endcase
		end
		// Engine takes the transmit word
		if (tx_take && !st_r.txe) begin
			st_nxt.tx_word = st_r.tx_buf;
			st_nxt.txe = 1'b1;
			if (st_r.ctrl1[SIC_C1_CRCEN] && spi_side) begin
				st_nxt.tx_checksum = sic_crc_step(st_r.tx_checksum, st_r.tx_buf, st_r.poly, wide);
			end
		end
		// Engine delivers a received word; a full buffer overflows
		if (rx_valid) begin
			if (st_r.rxf) begin
				st_nxt.ovr = 1'b1;
			end else begin
				st_nxt.rx_buf = sic_frame(rx_word, wide);
			end
			st_nxt.rxf = 1'b1;
			if (st_r.ctrl1[SIC_C1_CRCEN] && spi_side) begin
				st_nxt.rx_checksum = sic_crc_step(st_r.rx_checksum, sic_frame(rx_word, wide), st_r.poly, wide);
			end
		end
		// Checksums stay cleared while disabled
		if (!st_r.ctrl1[SIC_C1_CRCEN]) begin
			st_nxt.rx_checksum = SIC_RST_ZERO;
			st_nxt.tx_checksum = SIC_RST_ZERO;
		end
		// Error events win over clears
		if (mode_fault_evt) begin
			st_nxt.mmf = 1'b1;
		end
		if (crc_err_evt && spi_side) begin
			st_nxt.crcerr = 1'b1;
		end
		if (underrun_evt && !spi_side) begin
			st_nxt.udr = 1'b1;
		end
	end

	// State register
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			st_r <= '0;
			st_r.txe <= 1'b1;
			st_r.poly <= SIC_RST_POLY;
			st_r.clkp <= SIC_RST_CLKP;
		end else begin
			st_r <= st_nxt;
		end
	end

	// Outputs
	assign rdata = st_r.rdata;
	assign tx_word = st_r.tx_word;
	assign tx_ready = !st_r.txe;
	assign irq = (st_r.ctrl2[SIC_C2_TXEIE] & st_r.txe)
		| (st_r.ctrl2[SIC_C2_RXFIE] & st_r.rxf)
		| (st_r.ctrl2[SIC_C2_ERROR_IRQ_ENABLE] & (st_r.ovr | st_r.mmf | st_r.crcerr | st_r.udr));
	assign tx_dma_req = st_r.ctrl2[SIC_C2_TXDMA] & st_r.txe;
	assign rx_dma_req = st_r.ctrl2[SIC_C2_RXDMA] & st_r.rxf;
	assign spi_master = st_r.ctrl1[SIC_C1_MASTER];
	assign sel_oe = spi_master & st_r.ctrl2[SIC_C2_HWSEL];
	assign sel_out = 1'b0;
	assign frame_wide = wide;
	assign baud_divider_select = {st_r.ctrl2[SIC_C2_DIVHI], st_r.ctrl1[SIC_C1_DIVLO +: 3]};
	assign baud_ratio = 11'h002 << baud_divider_select;
	assign audio_mode_select = st_r.i2s[SIC_I2_MODE];
	assign audio_enable = st_r.i2s[SIC_I2_EN];
	assign audio_role_select = st_r.i2s[SIC_I2_ROLE +: 2];
	assign audio_framing_select = st_r.i2s[SIC_I2_STD +: 2];
	assign pulse_code_sync_length = st_r.i2s[SIC_I2_PCMLONG];
	assign audio_clock_idle_level = st_r.i2s[SIC_I2_CKPOL];
	assign audio_sample_length = st_r.i2s[SIC_I2_LEN +: 2];
	assign audio_ch32 = st_r.i2s[SIC_I2_CH32] | (audio_sample_length != SIC_LEN_16);
	assign audio_divider = {st_r.clkp[11:10], st_r.clkp[7:0], 1'b0} + {10'h000, st_r.clkp[SIC_CP_ODD]};
	assign audio_master_clock_out_enable = st_r.clkp[SIC_CP_MCLKOE];

	// Checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);

	property p_ovr_set;
		rx_valid && st_r.rxf |=> st_r.ovr && st_r.rxf;
	endproperty
	a_ovr_set: assert property (p_ovr_set) else $error("overrun not flagged");

	property p_mmf_clear;
		wr && addr == SIC_OFF_CTRL1 && st_r.sts_seen && !mode_fault_evt |=> !st_r.mmf;
	endproperty
	a_mmf_clear: assert property (p_mmf_clear) else $error("fault not cleared");

	property p_mmf_hold;
		st_r.mmf && !(wr && addr == SIC_OFF_CTRL1) |=> st_r.mmf;
	endproperty
	a_mmf_hold: assert property (p_mmf_hold) else $error("fault lost");

	property p_crc_w1;
		st_r.crcerr && wr && addr == SIC_OFF_STS && wdata[SIC_ST_CRC] |=> st_r.crcerr;
	endproperty
	a_crc_w1: assert property (p_crc_w1) else $error("write one cleared flag");

	property p_udr_rd;
		rd && addr == SIC_OFF_STS && !underrun_evt |=> !st_r.udr ##0 rdata[SIC_ST_UDR] == $past(st_r.udr);
	endproperty
	a_udr_rd: assert property (p_udr_rd) else $error("underrun read clear");

	property p_crc_zero;
		!st_r.ctrl1[SIC_C1_CRCEN] |=> st_r.rx_checksum == 16'h0000 && st_r.tx_checksum == 16'h0000;
	endproperty
	a_crc_zero: assert property (p_crc_zero) else $error("checksum not zeroed");

	property p_poly_rd;
		rd && addr == SIC_OFF_POLY && !wr |=> rdata == $past(st_r.poly);
	endproperty
	a_poly_rd: assert property (p_poly_rd) else $error("polynomial readback");

	property p_dma;
		tx_dma_req == (st_r.ctrl2[SIC_C2_TXDMA] && st_r.txe)
			&& rx_dma_req == (st_r.ctrl2[SIC_C2_RXDMA] && st_r.rxf);
	endproperty
	a_dma: assert property (p_dma) else $error("dma request");

	property p_sel;
		sel_oe |-> spi_master && st_r.ctrl2[SIC_C2_HWSEL] && !sel_out;
	endproperty
	a_sel: assert property (p_sel) else $error("select drive");

	property p_tx_empty;
		wr && addr == SIC_OFF_DATA && !tx_take |=> !st_r.txe && tx_ready
			&& st_r.tx_buf[7:0] == $past(wdata[7:0]);
	endproperty
	a_tx_empty: assert property (p_tx_empty) else $error("tx empty flag");

	property p_err_irq;
		st_r.ctrl2[SIC_C2_ERROR_IRQ_ENABLE] && (st_r.ovr || st_r.udr) |-> irq;
	endproperty
	a_err_irq: assert property (p_err_irq) else $error("error irq");

	property p_ratio;
		baud_divider_select == 4'h9 |-> baud_ratio == 11'h400;
	endproperty
	a_ratio: assert property (p_ratio) else $error("baud ratio");

	property p_busy;
		rd && addr == SIC_OFF_STS |=> rdata[SIC_ST_BUSY] == $past(busy);
	endproperty
	a_busy: assert property (p_busy) else $error("busy status");

	c_overrun: cover property (rx_valid && st_r.rxf);
	c_mmf_clear: cover property (st_r.mmf ##1 !st_r.mmf);
	c_crc_acc: cover property (st_r.ctrl1[SIC_C1_CRCEN] && rx_valid ##1 st_r.rx_checksum != 16'h0000);
	c_audio: cover property (audio_mode_select && underrun_evt ##1 st_r.udr);
endmodule

// ---- sim/sic_engine_model.sv ----
// Shift engine stand-in that delivers and takes words
`timescale 1ns/1ps
module sic_engine_model (
	input wire logic clk,
	input wire logic resetn,
	input wire logic rx_go,
	input wire logic [15:0] rx_in,
	input wire logic tx_go,
	input wire logic tx_ready,
	output logic busy,
	output logic rx_valid,
	output logic [15:0] rx_word,
	output logic tx_take
);
	// One-cycle transfers; take only a loaded buffer
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			rx_valid <= 1'b0;
			rx_word <= 16'h0000;
			tx_take <= 1'b0;
		end else begin
			rx_valid <= rx_go;
			rx_word <= rx_go ? rx_in : ~rx_word; // Stale word never holds
			tx_take <= tx_go && tx_ready && !tx_take;
		end
	end
	// Busy while a word moves
	assign busy = rx_valid | tx_take;
endmodule

// ---- sim/test_sic_regs.sv ----
// Self-checking bench of the serial control/status registers
`timescale 1ns/1ps
module test_sic_regs;
	import sic_pkg::*;
	logic clk = 1'b0;
	logic resetn = 1'b0;
	logic [5:0] addr = 6'h00;
	logic [15:0] wdata = 16'h0000;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic [2:0] evt = 3'h0;
	logic side = 1'b0;
	logic rx_go = 1'b0;
	logic tx_go = 1'b0;
	logic [15:0] rx_in = 16'h0000;
	logic [15:0] rdata, rx_word, tx_word;
	logic [10:0] baud_ratio;
	logic [3:0] div_sel;
	wire busy, rx_valid, tx_take, tx_ready;
	wire [6:0] fl;
	wire [11:0] cfg;
	wire [11:0] ck;
	int n_errors = 0;
	int num_checks = 0;
	int cyc = 0;
	logic [15:0] rv [10] = '{16'h0000, 16'h0000, 16'h0002, 16'h0000, 16'h0007,
		16'h0000, 16'h0000, 16'h0000, 16'h0002, 16'h0000};
	assign cfg[6] = 1'b0;
	sic_regs i_dut (
		.clk(clk), .resetn(resetn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
		.rdata(rdata), .busy(busy), .rx_valid(rx_valid), .rx_word(rx_word),
		.tx_take(tx_take), .tx_word(tx_word), .tx_ready(tx_ready),
		.mode_fault_evt(evt[0]), .crc_err_evt(evt[1]), .underrun_evt(evt[2]),
		.audio_side(side), .irq(fl[6]), .tx_dma_req(fl[5]), .rx_dma_req(fl[4]),
		.sel_out(fl[3]), .sel_oe(fl[2]), .spi_master(fl[1]), .frame_wide(fl[0]),
		.baud_divider_select(div_sel), .baud_ratio(baud_ratio),
		.audio_mode_select(cfg[11]), .audio_enable(cfg[10]),
		.audio_role_select(cfg[9:8]), .audio_framing_select(cfg[5:4]),
		.pulse_code_sync_length(cfg[7]), .audio_clock_idle_level(cfg[3]),
		.audio_sample_length(cfg[2:1]), .audio_ch32(cfg[0]),
		.audio_divider(ck[10:0]), .audio_master_clock_out_enable(ck[11])
	);
	sic_engine_model i_eng (
		.clk(clk), .resetn(resetn), .rx_go(rx_go), .rx_in(rx_in), .tx_go(tx_go),
		.tx_ready(tx_ready), .busy(busy), .rx_valid(rx_valid), .rx_word(rx_word),
		.tx_take(tx_take)
	);
	// Clock
	initial begin
		forever #5 clk = ~clk;
	end
	// Hang guard
	always @(posedge clk) begin
		cyc++;
		if (cyc == 4000) begin
			n_errors++;
			print_verdict();
		end
	end
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	task automatic chk(input logic [15:0] g, input logic [15:0] e);
		num_checks++;
		if (g !== e) begin
			n_errors++;
			$display("BAD %0t got %h expected %h", $time, g, e);
		end
	endtask
	task automatic wrr(input logic [5:0] a, input logic [15:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
		#1;
	endtask
	task automatic rdr(input logic [5:0] a, input logic [15:0] e);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		chk(rdata, e);
	endtask
	// Engine events: bit0 fault, bit1 checksum, bit2 underrun
	task automatic fire(input logic [2:0] m);
		@(posedge clk);
		evt <= m;
		@(posedge clk);
		evt <= 3'h0;
		#1;
	endtask
	task automatic eng(input logic r, input logic t, input logic [15:0] w);
		@(posedge clk);
		rx_in <= w;
		rx_go <= r;
		tx_go <= t;
		@(posedge clk);
		rx_go <= 1'b0;
		tx_go <= 1'b0;
		@(posedge clk);
		#1;
	endtask
	// Serial checksum, MSB first, zero start
	function automatic logic [15:0] crc_of(logic [15:0] d, logic [15:0] p, logic w);
		logic [15:0] c;
		logic fb;
		int n;
		c = 16'h0000;
		n = w ? 16 : 8;
		for (int i = n - 1; i >= 0; i--) begin
			fb = c[n-1] ^ d[i];
			c = c << 1;
			if (fb) c = c ^ p;
			if (!w) c[15:8] = 8'h00;
		end
		return c;
	endfunction
	// Main sequence
	initial begin
		logic [15:0] v;
		repeat (6) @(posedge clk);
		resetn <= 1'b1;
		for (int i = 0; i < 10; i++) rdr(6'(4 * i), rv[i]);
		chk(16'(baud_ratio), 16'h0002);
		chk(16'(ck), 16'h0004);
		$display("test 1 done");
		wrr(SIC_OFF_CTRL2, 16'hFFFF);
		rdr(SIC_OFF_CTRL2, 16'h01E7);
		chk(16'(fl[2]), 16'h0000);
		wrr(SIC_OFF_CTRL1, 16'h0C0C);
		chk(16'(div_sel), 16'h0009);
		chk(16'(baud_ratio), 16'h0400);
		chk(16'(fl), 16'h0067);
		wrr(SIC_OFF_I2S, 16'hFFFF);
		rdr(SIC_OFF_I2S, 16'h0FBF);
		chk(16'(cfg), 16'h0FBF);
		for (int k = 0; k < 4; k++) begin
			v = 16'((k << 8) | (k << 4) | ((k % 3) << 1));
			wrr(SIC_OFF_I2S, v);
			chk(16'(cfg), v | 16'(k % 3 != 0));
		end
		wrr(SIC_OFF_CLKP, 16'hFFFF);
		rdr(SIC_OFF_CLKP, 16'h0FFF);
		chk(16'(ck), 16'h0FFF);
		wrr(SIC_OFF_CLKP, 16'h0103);
		chk(16'(ck), 16'h0007);
		wrr(SIC_OFF_I2S, 16'h0000);
		wrr(SIC_OFF_CTRL1, 16'h0000);
		$display("test 2 done");
		wrr(SIC_OFF_CTRL2, 16'h0082);
		chk(16'(fl), 16'h0060);
		wrr(SIC_OFF_DATA, 16'h1234);
		chk(16'(fl), 16'h0000);
		chk(16'(tx_ready), 16'h0001);
		rdr(SIC_OFF_STS, 16'h0000);
		eng(1'b0, 1'b1, 16'h0000);
		chk(tx_word, 16'h0034);
		chk(16'(fl), 16'h0060);
		wrr(SIC_OFF_CTRL1, 16'h0800);
		wrr(SIC_OFF_CTRL2, 16'h0041);
		eng(1'b1, 1'b0, 16'hBEEF);
		chk(16'(fl), 16'h0051);
		rdr(SIC_OFF_STS, 16'h0003);
		rdr(SIC_OFF_DATA, 16'hBEEF);
		wrr(SIC_OFF_CTRL2, 16'h0020);
		eng(1'b1, 1'b0, 16'h1111);
		eng(1'b1, 1'b0, 16'h2222);
		chk(16'(fl), 16'h0041);
		rdr(SIC_OFF_STS, 16'h0043);
		rdr(SIC_OFF_DATA, 16'h1111);
		rdr(SIC_OFF_STS, 16'h0002);
		$display("test 3 done");
		wrr(SIC_OFF_CTRL1, 16'h0800);
		fire(3'h1);
		chk(16'(fl[6]), 16'h0001);
		wrr(SIC_OFF_CTRL1, 16'h0800);
		rdr(SIC_OFF_STS, 16'h0022);
		wrr(SIC_OFF_CTRL1, 16'h0800);
		rdr(SIC_OFF_STS, 16'h0002);
		@(posedge clk);
		side <= 1'b1;
		fire(3'h6);
		rdr(SIC_OFF_STS, 16'h0012);
		wrr(SIC_OFF_STS, 16'h0010);
		rdr(SIC_OFF_STS, 16'h0012);
		wrr(SIC_OFF_STS, 16'h0000);
		rdr(SIC_OFF_STS, 16'h0002);
		wrr(SIC_OFF_I2S, 16'h0800);
		fire(3'h6);
		rdr(SIC_OFF_STS, 16'h000E);
		rdr(SIC_OFF_STS, 16'h0006);
		wrr(SIC_OFF_I2S, 16'h0000);
		$display("test 4 done");
		wrr(SIC_OFF_CTRL1, 16'h2000);
		wrr(SIC_OFF_DATA, 16'h125A);
		// Status read lands on the edge where the engine takes the word
		@(posedge clk);
		tx_go <= 1'b1;
		@(posedge clk);
		tx_go <= 1'b0;
		addr <= SIC_OFF_STS;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		chk(rdata, 16'h0080);
		rdr(SIC_OFF_TX_CHECKSUM, crc_of(16'h125A, 16'h0007, 1'b0));
		wrr(SIC_OFF_CTRL1, 16'h0000);
		rdr(SIC_OFF_TX_CHECKSUM, 16'h0000);
		wrr(SIC_OFF_POLY, 16'h8005);
		rdr(SIC_OFF_POLY, 16'h8005);
		wrr(SIC_OFF_CTRL1, 16'h2800);
		eng(1'b1, 1'b0, 16'h1234);
		rdr(SIC_OFF_RX_CHECKSUM, crc_of(16'h1234, 16'h8005, 1'b1));
		wrr(SIC_OFF_CTRL1, 16'h0800);
		rdr(SIC_OFF_RX_CHECKSUM, 16'h0000);
		$display("test 5 done");
		print_verdict();
	end
endmodule
